// [hw/fram_pkg.sv]
// shared constants for the two-wire memory slave
package fram_pkg;
    // array shape
    localparam int DATA_W = 8;
    localparam int ADDR_W = 9;
    localparam int MEM_DEPTH = 512;
    localparam logic [ADDR_W-1:0] LOC_RESET = 9'h000;
    localparam logic [ADDR_W-1:0] LOC_STEP = 9'h001;
    // slave address byte fields
    localparam int SA_TYPE_HI = 7;
    localparam int SA_TYPE_LO = 4;
    localparam int SA_SEL_HI = 3;
    localparam int SA_SEL_LO = 2;
    localparam int SA_PAGE_BIT = 1;
    localparam int SA_RNW_BIT = 0;
    // device type code; the value is arbitrary
    localparam logic [3:0] DEV_TYPE = 4'h5;
    // bits per byte before the acknowledge slot
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [3:0] BIT_CNT_STEP = 4'h1;
    // write queue shape: {location, data}
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = ADDR_W + DATA_W;
    // bus sequencing states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WORD,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_MACK
    } bus_state_e;
endpackage

// [hw/byte_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
// small flop-based queue with valid/ready on both sides
module byte_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = PW'(0) + (PW+1)'(DEPTH);

    logic [WIDTH-1:0] store_ff [DEPTH];  // entry storage
    logic [PW-1:0] wr_ptr_ff;  // next slot to fill
    logic [PW-1:0] rd_ptr_ff;  // oldest entry
    logic [PW:0] count_ff;  // entries held
    logic push;
    logic pop;

    assign in_ready = (count_ff != FULL_CNT);
    assign out_valid = (count_ff != '0);
    assign out_data = store_ff[rd_ptr_ff];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointer and fill level bookkeeping
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= PW'(wr_ptr_ff + 1'b1);
            if (pop)
                rd_ptr_ff <= PW'(rd_ptr_ff + 1'b1);
            // simultaneous push and pop keeps the level
            if (push && !pop)
                count_ff <= (PW+1)'(count_ff + 1'b1);
            else if (pop && !push)
                count_ff <= (PW+1)'(count_ff - 1'b1);
        end
    end

    // data storage, no reset needed on the payload
    always_ff @(posedge sys_clk)
    begin
        if (push)
            store_ff[wr_ptr_ff] <= in_data;
    end
endmodule
`default_nettype wire

// [hw/fram_two_wire_slave_port.sv]
// Behaviour
// - sample on scl rise, change on fall
// - write protect high blocks all writes
// - respond only when select bits match straps
// - open straps and protect read low
// - array of 512 byte locations
// - location is page bit plus word
// - writes land before next transaction
// - slave only, never drives scl
// - sda rise with scl high is stop
// - stop abandons pending operation
// - sda fall with scl high is start
// - start aborts and awaits slave address
// - sda only pulled low or released
// - power-on reset is only reset
// - slave byte: type, select, page, rnw
// - location counter increments and wraps
// - ninth clock carries the acknowledge
// - protected writes unacked, counter held
`timescale 1ns/1ns
`default_nettype none
module fram_two_wire_slave_port
    import fram_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] chip_select_straps,
    input wire logic write_protect,
    output logic bus_active
);
    // pin synchronisers, first stage read only by the second
    logic scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic sda_s1_ff, sda_s2_ff, sda_d_ff;
    logic [1:0] sel_s1_ff, sel_s2_ff;
    logic wp_s1_ff, wp_s2_ff;
    // bus events derived from synchronised levels
    logic scl_rise, scl_fall, start_det, stop_det;
    // protocol state
    bus_state_e state_ff;  // current bus phase
    bus_state_e ret_ff;  // phase after the ack slot
    logic [3:0] bit_cnt_ff;  // rising edges in this byte
    logic [7:0] rx_ff;  // incoming shift register
    logic [7:0] tx_ff;  // outgoing shift register
    logic rnw_ff;  // transaction is a read
    logic mack_ff;  // master acknowledged last read byte
    logic [ADDR_W-1:0] loc_ff;  // page bit and word latch
    logic sda_oe_ff;  // pulling sda low
    logic sda_out_ff;  // driven level, always low
    logic active_ff;  // a transaction is in progress
    // array and write path
    logic [DATA_W-1:0] mem_ff [MEM_DEPTH];
    logic byte_done, addr_hit, wr_take, fetch_now;
    logic q_in_ready, q_out_valid, q_out_ready;
    logic [FIFO_W-1:0] q_out_data;
    logic [DATA_W-1:0] fetch_byte;

    // slave byte decode: type and select bits against straps
    function automatic logic is_ours(input logic [7:0] b, input logic [1:0] straps);
        is_ours = (b[SA_TYPE_HI:SA_TYPE_LO] == DEV_TYPE) && (b[SA_SEL_HI:SA_SEL_LO] == straps);
    endfunction

    // next location, rolling over from the top back to zero
    function automatic logic [ADDR_W-1:0] nxt_loc(input logic [ADDR_W-1:0] l);
        nxt_loc = ADDR_W'(l + LOC_STEP);
    endfunction

    // scl is only ever sampled here; nothing in this block drives it
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_s1_ff <= scl_in;
            scl_s2_ff <= scl_s1_ff;
            scl_d_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_d_ff <= sda_s2_ff;
        end
    end

    // straps and protect; open pins arrive low through pad pull-downs
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sel_s1_ff <= 2'h0;
            sel_s2_ff <= 2'h0;
            wp_s1_ff <= 1'b0;
            wp_s2_ff <= 1'b0;
        end
        else
        begin
            sel_s1_ff <= chip_select_straps;
            sel_s2_ff <= sel_s1_ff;
            wp_s1_ff <= write_protect;
            wp_s2_ff <= wp_s1_ff;
        end
    end

    // edge and condition decode on synchronised copies
    assign scl_rise = scl_s2_ff & ~scl_d_ff;
    assign scl_fall = ~scl_s2_ff & scl_d_ff;
    assign stop_det = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
    assign start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;

    // a byte is complete at the fall that ends its eighth clock
    assign byte_done = scl_fall && (bit_cnt_ff == BITS_PER_BYTE);
    assign addr_hit = is_ours(rx_ff, sel_s2_ff);
    // a data byte is taken only if unprotected and the queue has room
    assign wr_take = byte_done && (state_ff == ST_WDATA) && !wp_s2_ff && q_in_ready;
    // array read at the fall that starts a read byte
    assign fetch_now = scl_fall && (((state_ff == ST_ACK) && (ret_ff == ST_RDATA))
                                    || ((state_ff == ST_MACK) && mack_ff));
    assign fetch_byte = mem_ff[loc_ff];

    // bus phase sequencing; reset leaves the port idle until a start
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= ST_IDLE;
            ret_ff <= ST_IDLE;
            rnw_ff <= 1'b0;
        end
        else if (start_det)
        begin
            state_ff <= ST_ADDR;
        end
        else if (stop_det)
        begin
            state_ff <= ST_IDLE;
        end
        else if (scl_fall)
        begin
            unique case (state_ff)
                ST_IDLE:
                    state_ff <= ST_IDLE;
                ST_ADDR:
                begin
                    if (byte_done)
                    begin
                        // a foreign address leaves us deaf until next start
                        state_ff <= addr_hit ? ST_ACK : ST_IDLE;
                        rnw_ff <= rx_ff[SA_RNW_BIT];
                        ret_ff <= rx_ff[SA_RNW_BIT] ? ST_RDATA : ST_WORD;
                    end
                end
                ST_WORD:
                begin
                    if (byte_done)
                    begin
                        state_ff <= ST_ACK;
                        ret_ff <= ST_WDATA;
                    end
                end
                ST_WDATA:
                begin
                    if (byte_done)
                    begin
                        // no ack ends the operation
                        state_ff <= wr_take ? ST_ACK : ST_IDLE;
                        ret_ff <= ST_WDATA;
                    end
                end
                ST_ACK:
                    state_ff <= ret_ff;
                ST_RDATA:
                begin
                    if (byte_done)
                        state_ff <= ST_MACK;
                end
                ST_MACK:
                begin
                    // master nack ends the read
                    state_ff <= mack_ff ? ST_RDATA : ST_IDLE;
                end
            endcase
        end
    end

    // bit counting and shifting in, on the rising edge only
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_cnt_ff <= BIT_CNT_RESET;
            rx_ff <= 8'h00;
            mack_ff <= 1'b0;
        end
        else if (start_det || stop_det)
        begin
            bit_cnt_ff <= BIT_CNT_RESET;
        end
        else if (scl_rise)
        begin
            if (state_ff == ST_MACK)
                mack_ff <= ~sda_s2_ff;
            else if (state_ff != ST_IDLE && state_ff != ST_ACK)
            begin
                rx_ff <= {rx_ff[6:0], sda_s2_ff};
                bit_cnt_ff <= 4'(bit_cnt_ff + BIT_CNT_STEP);
            end
        end
        else if (scl_fall && (state_ff == ST_ACK || state_ff == ST_MACK))
        begin
            bit_cnt_ff <= BIT_CNT_RESET;
        end
    end

    // sda drive: pull low or release, changed on the falling edge
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sda_oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
            tx_ff <= 8'h00;
        end
        else if (start_det || stop_det)
        begin
            // any condition frees the line at once
            sda_oe_ff <= 1'b0;
        end
        else if (fetch_now)
        begin
            tx_ff <= fetch_byte;
            sda_oe_ff <= ~fetch_byte[7];
        end
        else if (scl_fall)
        begin
            sda_out_ff <= 1'b0;
            unique case (state_ff)
                ST_ADDR:
                    sda_oe_ff <= byte_done && addr_hit;
                ST_WORD:
                    sda_oe_ff <= byte_done;
                ST_WDATA:
                    sda_oe_ff <= wr_take;
                ST_RDATA:
                begin
                    // msb first; release for the master's ack slot
                    if (byte_done)
                        sda_oe_ff <= 1'b0;
                    else
                    begin
                        sda_oe_ff <= ~tx_ff[6];
                        tx_ff <= {tx_ff[6:0], 1'b0};
                    end
                end
                default:
                    sda_oe_ff <= 1'b0;
            endcase
        end
    end

    // location: page from slave byte, word from first written byte
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            loc_ff <= LOC_RESET;
        else if (scl_fall && byte_done)
        begin
            if (state_ff == ST_ADDR && addr_hit)
                loc_ff[ADDR_W-1] <= rx_ff[SA_PAGE_BIT];
            else if (state_ff == ST_WORD)
                loc_ff[7:0] <= rx_ff;
            else if (wr_take || state_ff == ST_RDATA)
                loc_ff <= nxt_loc(loc_ff);
        end
    end

    // transaction flag for status
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            active_ff <= 1'b0;
        else
            active_ff <= (state_ff != ST_IDLE);
    end

    // written bytes queue here; draining yields only to a read fetch
    assign q_out_ready = ~fetch_now;

    byte_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_queue (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(wr_take),
        .in_ready(q_in_ready),
        .in_data({loc_ff, rx_ff}),
        .out_valid(q_out_valid),
        .out_ready(q_out_ready),
        .out_data(q_out_data)
    );

    // array write; a queued byte lands within a few system clocks
    always_ff @(posedge sys_clk)
    begin
        if (q_out_valid && q_out_ready)
            mem_ff[q_out_data[FIFO_W-1:DATA_W]] <= q_out_data[DATA_W-1:0];
    end

    assign sda_out = sda_out_ff;
    assign sda_oe = sda_oe_ff;
    assign bus_active = active_ff;

    // checks
    sequence s_addr_byte;
        state_ff == ST_ADDR && byte_done;
    endsequence
    sequence s_wdata_byte;
        state_ff == ST_WDATA && byte_done;
    endsequence

    a_sda_low_only: assert property (@(posedge sys_clk) disable iff (!reset_n) !sda_out)
        else $error("sda driven high");
    a_oe_on_fall: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $changed(sda_oe_ff) |-> $past(scl_fall || start_det || stop_det))
        else $error("sda moved off the falling edge");
    a_start_rearms: assert property (@(posedge sys_clk) disable iff (!reset_n)
        start_det |=> state_ff == ST_ADDR && !sda_oe && bit_cnt_ff == BIT_CNT_RESET)
        else $error("start did not rearm address phase");
    a_stop_abandons: assert property (@(posedge sys_clk) disable iff (!reset_n)
        stop_det |=> state_ff == ST_IDLE && !sda_oe)
        else $error("stop did not abandon operation");
    a_strap_mismatch: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_addr_byte and (rx_ff[SA_SEL_HI:SA_SEL_LO] != sel_s2_ff) |=> !sda_oe && state_ff == ST_IDLE)
        else $error("acked foreign select bits");
    a_addr_ack: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_addr_byte and addr_hit |=> sda_oe && state_ff == ST_ACK)
        else $error("own address not acked");
    a_wp_blocks: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_wdata_byte and wp_s2_ff |=> !sda_oe && loc_ff == $past(loc_ff) && !q_out_valid)
        else $error("protected write accepted");
    a_loc_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_take |=> loc_ff == nxt_loc($past(loc_ff)))
        else $error("location did not step");
    a_write_lands: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_take |-> ##[1:16] !q_out_valid)
        else $error("write not landed in time");
    a_rx_on_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $changed(rx_ff) |-> $past(scl_rise))
        else $error("data sampled off the rising edge");
    a_idle_deaf: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ST_IDLE && !start_det |=> state_ff == ST_IDLE && !sda_oe)
        else $error("idle port reacted without start");
endmodule
`default_nettype wire

// [sim/two_wire_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
// bus master model: owns scl, only pulls sda low or lets it go
module two_wire_master_model
(
    input wire logic sys_clk,
    input wire logic sda_wire,
    output var logic scl,
    output var logic sda_low
);
    // both lines released; scl stands still high between frames
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // quarter of the 160 ns bus period, stepped on the falling system edge
    task automatic qtr();
        repeat (4) @(negedge sys_clk);
    endtask
    // start from idle, or repeated start with scl low
    task automatic start();
        sda_low = 1'b0;
        qtr();
        scl = 1'b1;
        qtr();
        sda_low = 1'b1;
        qtr();
        scl = 1'b0;
        qtr();
    endtask
    // only called once the device has let sda go
    task automatic stop();
        sda_low = 1'b1;
        qtr();
        scl = 1'b1;
        qtr();
        sda_low = 1'b0;
        qtr();
    endtask
    // one clock: data moves while scl is low, sampled mid-high
    task automatic bit_slot(input logic tx, output logic rx);
        sda_low = ~tx;
        qtr();
        scl = 1'b1;
        qtr();
        rx = sda_wire;
        qtr();
        scl = 1'b0;
        qtr();
    endtask
    // eight bits msb first, then the acknowledge clock
    task automatic xfer(input logic [7:0] tx, input logic mst_ack, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_slot(tx[i], rx[i]);
        bit_slot(~mst_ack, a);
        ack = ~a;
    endtask
    // leading bits of a byte only, so the byte can be cut short
    task automatic partial(input logic [7:0] tx, input int n);
        logic r;
        for (int i = 7; i > 7 - n; i--)
            bit_slot(tx[i], r);
    endtask
endmodule
`default_nettype wire

// [sim/tb_fram_two_wire_slave_port.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_fram_two_wire_slave_port
    import fram_pkg::*;
;
    localparam int LIMIT = 30000; // whole run needs about a third of this
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] chip_select_straps = 2'b00; // straps left low as if open
    logic write_protect = 1'b0;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic bus_active;
    logic scl_q = 1'b1; // last cycle's views for the monitor
    logic oe_q = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    wire logic sda_wire = ~(sda_oe | sda_low); // pull-up wins unless someone pulls

    always #5 sys_clk = ~sys_clk;

    fram_two_wire_slave_port dut (.sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(chip_select_straps),
        .write_protect(write_protect), .bus_active(bus_active));
    two_wire_master_model master (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
            fails++;
        end
    endtask
    task automatic cmp1(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: %s got %b", $time, what, got);
            fails++;
        end
    endtask
    function automatic logic [7:0] slave(input logic [1:0] sel, input logic page, input logic rnw);
        return {DEV_TYPE, sel, page, rnw};
    endfunction
    // start, slave byte and word byte; leaves the bus open for data
    task automatic set_addr(input logic [8:0] loc);
        logic [7:0] rx;
        logic ack;
        master.start();
        master.xfer(slave(chip_select_straps, loc[8], 1'b0), 1'b0, rx, ack);
        cmp1(ack, 1'b1, "slave byte ack");
        master.xfer(loc[7:0], 1'b0, rx, ack);
        cmp1(ack, 1'b1, "word byte ack");
    endtask
    task automatic put(input logic [7:0] d, input logic exp_ack);
        logic [7:0] rx;
        logic ack;
        master.xfer(d, 1'b0, rx, ack);
        cmp1(ack, exp_ack, "data byte ack");
    endtask
    // current-location read of n bytes, nack on the last, then stop
    task automatic get(input logic page, input logic [7:0] exp [3], input int n);
        logic [7:0] rx;
        logic ack;
        master.start();
        master.xfer(slave(chip_select_straps, page, 1'b1), 1'b0, rx, ack);
        cmp1(ack, 1'b1, "read slave ack");
        for (int i = 0; i < n; i++)
        begin
            master.xfer(8'hFF, i < n - 1, rx, ack);
            cmp(rx, exp[i], "read data");
        end
        repeat (4) @(negedge sys_clk);
        cmp1(sda_oe, 1'b0, "sda held after nack");
        master.stop();
        repeat (8) @(negedge sys_clk);
        cmp1(bus_active, 1'b0, "busy after stop");
    endtask

    task automatic t_reset_idle();
        logic [7:0] rx;
        logic ack;
        cmp1(sda_oe, 1'b0, "sda after reset");
        cmp1(bus_active, 1'b0, "busy after reset");
        // scl drops first, so the byte below carries no start
        master.partial(8'hFF, 1);
        master.xfer(slave(2'b00, 1'b0, 1'b0), 1'b0, rx, ack);
        cmp1(ack, 1'b0, "ack with no start");
        master.stop();
    endtask
    // top of the array wraps to zero, the page bit carrying
    task automatic t_wrap();
        set_addr(9'h1FE);
        put(8'hA1, 1'b1);
        put(8'hB2, 1'b1);
        put(8'hC3, 1'b1);
        master.stop();
        set_addr(9'h1FE);
        get(1'b1, '{8'hA1, 8'hB2, 8'hC3}, 3);
        set_addr(9'h0FE);
        put(8'h11, 1'b1);
        master.stop();
        get(1'b1, '{8'hB2, 8'h00, 8'h00}, 1);
    endtask
    // every strap setting, each select bit flipped, and a wrong type
    task automatic t_select();
        logic [7:0] rx;
        logic ack;
        for (int s = 0; s < 4; s++)
        begin
            chip_select_straps = 2'(s);
            repeat (4) @(negedge sys_clk);
            master.start();
            master.xfer(slave(2'(s), 1'b0, 1'b0), 1'b0, rx, ack);
            cmp1(ack, 1'b1, "matching select");
            master.start();
            master.xfer(slave(2'(s) ^ 2'b01, 1'b0, 1'b0), 1'b0, rx, ack);
            cmp1(ack, 1'b0, "low select bit off");
            master.start();
            master.xfer(slave(2'(s) ^ 2'b10, 1'b0, 1'b0), 1'b0, rx, ack);
            cmp1(ack, 1'b0, "high select bit off");
            master.stop();
        end
        chip_select_straps = 2'b00;
        master.start();
        master.xfer({DEV_TYPE ^ 4'h1, 4'h0}, 1'b0, rx, ack);
        cmp1(ack, 1'b0, "wrong device type");
        master.stop();
    endtask
    // protected byte refused, array and location left alone
    task automatic t_protect();
        set_addr(9'h010);
        put(8'h3C, 1'b1);
        master.stop();
        write_protect = 1'b1;
        repeat (4) @(negedge sys_clk);
        set_addr(9'h010);
        put(8'h77, 1'b0);
        master.stop();
        write_protect = 1'b0;
        repeat (4) @(negedge sys_clk);
        get(1'b0, '{8'h3C, 8'h00, 8'h00}, 1);
        set_addr(9'h010);
        put(8'h77, 1'b1);
        set_addr(9'h010);
        get(1'b0, '{8'h77, 8'h00, 8'h00}, 1);
    endtask
    // a byte cut short by start or stop writes nothing
    task automatic t_abort();
        set_addr(9'h020);
        put(8'h5A, 1'b1);
        master.stop();
        set_addr(9'h020);
        master.partial(8'h99, 7);
        get(1'b0, '{8'h5A, 8'h00, 8'h00}, 1);
        set_addr(9'h020);
        master.partial(8'h99, 7);
        master.stop();
        get(1'b0, '{8'h5A, 8'h00, 8'h00}, 1);
    endtask

    // device only pulls low, and moves sda only while scl is low
    always @(posedge sys_clk)
    begin
        scl_q <= scl;
        oe_q <= sda_oe;
        if (sda_oe === 1'b1 && sda_out !== 1'b0)
        begin
            $display("wrong value at %0t: sda driven high", $time);
            fails++;
        end
        if (reset_n && scl && scl_q && sda_oe !== oe_q)
        begin
            $display("wrong value at %0t: sda moved with scl high", $time);
            fails++;
        end
    end
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            $display("wrong value at %0t: run did not finish", $time);
            fails++;
            results();
        end
    end
    initial
    begin
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        t_reset_idle();
        t_wrap();
        t_select();
        t_protect();
        t_abort();
        results();
    end
endmodule
`default_nettype wire
